// ==== src/cache_sysport_config_chain.sv ====
// write-once configuration chain loaded from the serial config rom
// What this block does
// (RQ1) shift all 367 bits in msb first during reset; keep low 303
// (RQ2) field lsb sits first in chain; fields run from lsb end up
// (RQ3) duplicate copies must match originals; device may use either
// (RQ4) skew fill flag and copy set only at 1.5x cache ratio
// (RQ5) at most six data cache victims accumulate before streaming
// (RQ6) eight bit decoded victim threshold starts streamed writes
// (RQ7) one-hot system ratio: 1.5x, 2.0x, 2.5x, 3.0x
// (RQ8) inhibit bit stops ack counter increment on victim reads
// (RQ9) idle bubbles: ww and rr one bit, rw six bits, wr four bits
// (RQ10) high ratio bit set for cache ratios 4.0x through 8.0x
// (RQ11) late write upper flag when count over 3, or 3 and proc over 1
// (RQ12) phase align bit starts transactions on first phase rise
// (RQ13) cache clock phase delay codes give 0,0,1,2 phases
// (RQ14) two bit system delay gives 0 to 2 phases before outputs
// (RQ15) two bit presets seed unload pointers for system and cache
// (RQ16) rise and fall forwarded clock enables must be loaded set
// (RQ17) separate bits pick tag update on fall or rise edge
// (RQ18) forwarded clock reset delayed by core, proc and frame counts
// (RQ19) jitter bit adds a core cycle to the write path
// (RQ20) fill commands held a four bit number of core cycles
// (RQ21) data valid delayed by two bit count of cache clocks
// (RQ22) cache clock delayable 0 to 3 core cycles by two bit field
// (RQ23) clock generator vectors: feedback 8, load 16, phase 4, frame 5
// (RQ24) field sets write data delay in cache clocks
// (RQ25) fields frozen after load until next hardware reset
// (RQ26) one bit per loader clock; fields valid after final bit
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "cfg_chain_regs.svh"
module cache_sysport_config_chain (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // serial config rom stream
    input wire logic loadStart,
    input wire logic romBitValid,
    input wire logic romBit,
    output logic romReady,
    output logic chainOut,
    output logic loadDone,
    // decoded controls
    output logic skew_fill_flag,
    output logic [7:0] victim_stream_threshold,
    output logic [3:0] sys_ratio_onehot,
    output logic victim_read_ack_inhibit,
    output logic ext_cache_ww_gap,
    output logic [5:0] ext_cache_rw_gap,
    output logic ext_cache_rr_gap,
    output logic [3:0] ext_cache_wr_gap,
    output logic late_write_upper_flag,
    output logic [1:0] sys_fwd_phase_delay,
    output logic [1:0] sys_unload_ptr_preset,
    output logic [1:0] cache_unload_ptr_preset,
    output logic sys_fwd_rise_enable,
    output logic sys_fwd_fall_enable,
    output logic [3:0] fwdrst_core_delay,
    output logic [2:0] fwdrst_proc_delay,
    output logic [1:0] fwdrst_frame_delay,
    output logic write_path_extra_cycle,
    output logic [3:0] fill_cmd_delay,
    output logic [1:0] data_valid_delay,
    output logic [1:0] ext_cache_clock_cycle_delay,
    output logic [7:0] sys_shift_feedback_points,
    output logic [15:0] sys_shift_load_vector,
    output logic [3:0] sys_second_phase_enables,
    output logic [4:0] frame_ratio_vector,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire cfg_chain_pkg::word_t hwdata,
    output cfg_chain_pkg::word_t hrdata,
    output logic hreadyout,
    output logic hresp
);
    import cfg_chain_pkg::*;

    logic [`CHAIN_ALLOC-1:0] chain_ff;
    logic [`CHAIN_CNT_W-1:0] count_ff;
    load_e state_ff;
    logic shiftEn;
    logic [`CHAIN_USED-1:0] used;
    logic [`CHAIN_ALLOC-1:0] nxt_chain;

    // a bit is accepted only while shifting; one per clock at most
    assign shiftEn = (state_ff == LD_SHIFT) && romBitValid; // RQ26
    assign used = chain_ff[`CHAIN_USED-1:0];
    // msb first from rom: each new bit enters position 0 and moves up,
    // so the last bit sent ends as the chain lsb; the first 64 bits
    // sent are surplus and pass out of the top of the used part
    assign nxt_chain = {chain_ff[`CHAIN_ALLOC-2:0], romBit}; // RQ1 RQ2

    // loader state machine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= LD_IDLE;
        end else begin
            case (state_ff)
                LD_IDLE: begin
                    if (loadStart) begin
                        state_ff <= LD_SHIFT;
                    end
                end
                LD_SHIFT: begin
                    if (shiftEn &&
                        count_ff == 9'(`CHAIN_ALLOC - 1)) begin
                        state_ff <= LD_DONE; // RQ1
                    end
                end
                LD_DONE: state_ff <= LD_DONE; // RQ25
                default: state_ff <= LD_IDLE;
            endcase
        end
    end

    // bit counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= 9'h000;
        end else if (shiftEn) begin
            count_ff <= count_ff + 9'h001; // RQ26
        end
    end

    // chain storage, frozen once loaded
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chain_ff <= '0;
        end else if (shiftEn) begin
            chain_ff <= nxt_chain; // RQ25 RQ26
        end
    end

    // handshake and shift-out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            romReady <= 1'b0;
            chainOut <= 1'b0;
            loadDone <= 1'b0;
        end else begin
            romReady <= (state_ff == LD_IDLE && loadStart) ||
                        (state_ff == LD_SHIFT && !(shiftEn &&
                         count_ff == 9'(`CHAIN_ALLOC - 1)));
            if (shiftEn) begin
                // bit leaving the far end of the used part
                chainOut <= chain_ff[`CHAIN_USED-1]; // RQ1
            end
            loadDone <= (state_ff == LD_SHIFT && shiftEn &&
                         count_ff == 9'(`CHAIN_ALLOC - 1)) ||
                        (state_ff == LD_DONE); // RQ26
        end
    end

    // decoded fields: zero until the final bit, then held
    // registering them costs a cycle but keeps outputs glitch free
    // nothing but the loader reaches these flops after reset

    // bus format and victim handling
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            skew_fill_flag <= 1'b0;
            victim_stream_threshold <= 8'h00;
            sys_ratio_onehot <= 4'h0;
            victim_read_ack_inhibit <= 1'b0;
        end else if (state_ff == LD_DONE) begin
            // original copy used; the duplicate must agree with it
            skew_fill_flag <= used[`F_SKEW]; // RQ3 RQ4
            victim_stream_threshold <=
                used[`F_VICTHR +: 8]; // RQ5 RQ6
            sys_ratio_onehot <= used[`F_SYSRATIO +: 4]; // RQ7
            victim_read_ack_inhibit <= used[`F_RDVIC_INH]; // RQ8
        end
    end

    // external cache bubbles and late write flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_cache_ww_gap <= 1'b0;
            ext_cache_rw_gap <= 6'h00;
            ext_cache_rr_gap <= 1'b0;
            ext_cache_wr_gap <= 4'h0;
            late_write_upper_flag <= 1'b0;
        end else if (state_ff == LD_DONE) begin
            ext_cache_ww_gap <= used[`F_WW]; // RQ9
            ext_cache_rw_gap <= used[`F_RW +: 6]; // RQ9
            ext_cache_rr_gap <= used[`F_RR]; // RQ9
            ext_cache_wr_gap <= used[`F_WR +: 4]; // RQ9
            late_write_upper_flag <= used[`F_LW_UPPER]; // RQ11
        end
    end

    // forwarded system clock delay, edges and unload pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_fwd_phase_delay <= 2'h0;
            sys_unload_ptr_preset <= 2'h0;
            cache_unload_ptr_preset <= 2'h0;
            sys_fwd_rise_enable <= 1'b0;
            sys_fwd_fall_enable <= 1'b0;
        end else if (state_ff == LD_DONE) begin
            sys_fwd_phase_delay <= used[`F_SYS_DELAY +: 2]; // RQ14
            sys_unload_ptr_preset <= used[`F_SYS_PRESET +: 2]; // RQ15
            cache_unload_ptr_preset <=
                used[`F_CACHE_PRESET +: 2]; // RQ15
            sys_fwd_rise_enable <= used[`F_SYS_RISE]; // RQ16
            sys_fwd_fall_enable <= used[`F_SYS_FALL]; // RQ16
        end
    end

    // forwarded clock reset delays
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fwdrst_core_delay <= 4'h0;
            fwdrst_proc_delay <= 3'h0;
            fwdrst_frame_delay <= 2'h0;
        end else if (state_ff == LD_DONE) begin
            fwdrst_core_delay <= used[`F_FR_CORE +: 4]; // RQ18
            fwdrst_proc_delay <= used[`F_FR_PROC +: 3]; // RQ18
            fwdrst_frame_delay <= used[`F_FR_FRAME +: 2]; // RQ18
        end
    end

    // system port and cache clock delays
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_path_extra_cycle <= 1'b0;
            fill_cmd_delay <= 4'h0;
            data_valid_delay <= 2'h0;
            ext_cache_clock_cycle_delay <= 2'h0;
        end else if (state_ff == LD_DONE) begin
            write_path_extra_cycle <= used[`F_JITTER]; // RQ19
            fill_cmd_delay <= used[`F_FILL_DLY +: 4]; // RQ20
            data_valid_delay <= used[`F_DV_DLY +: 2]; // RQ21
            ext_cache_clock_cycle_delay <=
                used[`F_CCLK_DLY +: 2]; // RQ22
        end
    end

    // forwarded clock generator vectors
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_shift_feedback_points <= 8'h00;
            sys_shift_load_vector <= 16'h0000;
            sys_second_phase_enables <= 4'h0;
            frame_ratio_vector <= 5'h00;
        end else if (state_ff == LD_DONE) begin
            sys_shift_feedback_points <= used[`F_SYS_FDBK +: 8]; // RQ23
            sys_shift_load_vector <= used[`F_SYS_LOAD +: 16]; // RQ23
            sys_second_phase_enables <= used[`F_SYS_BPH +: 4]; // RQ23
            frame_ratio_vector <= used[`F_FRAME +: 5]; // RQ23
        end
    end

    // cache-side fields shown only through the CFG3 and CFG4 registers;
    // held in flops of their own so a read during the load shows zero
    logic [31:0] cacheWord;
    logic [2:0] phaseCount;
    logic [2:0] cachePhase_ff;
    logic hiRatio_ff;
    logic phaseAlign_ff;
    logic tagFall_ff;
    logic tagRise_ff;
    logic cacheRise_ff;
    logic cacheFall_ff;
    logic wdataDly_ff;
    logic io32_ff;
    always_comb begin
        // code 0 and 1 both mean no phase delay
        case (used[`F_CACHE_PHDLY +: 2])
            2'h2: phaseCount = 3'h1; // RQ13
            2'h3: phaseCount = 3'h2; // RQ13
            default: phaseCount = 3'h0; // RQ13
        endcase
    end

    // cache-side flops, loaded together with the decoded outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cachePhase_ff <= 3'h0;
            hiRatio_ff <= 1'b0;
            phaseAlign_ff <= 1'b0;
            tagFall_ff <= 1'b0;
            tagRise_ff <= 1'b0;
            cacheRise_ff <= 1'b0;
            cacheFall_ff <= 1'b0;
            wdataDly_ff <= 1'b0;
            io32_ff <= 1'b0;
        end else if (state_ff == LD_DONE) begin
            cachePhase_ff <= phaseCount; // RQ13
            hiRatio_ff <= used[`F_HIRATIO]; // RQ10
            phaseAlign_ff <= used[`F_PHASE_ALIGN]; // RQ12
            tagFall_ff <= used[`F_TAG_FALL]; // RQ17
            tagRise_ff <= used[`F_TAG_RISE]; // RQ17
            cacheRise_ff <= used[`F_CACHE_RISE]; // RQ16
            cacheFall_ff <= used[`F_CACHE_FALL]; // RQ16
            wdataDly_ff <= used[`F_WDATA_DLY]; // RQ24
            io32_ff <= used[`F_IO32]; // RQ2
        end
    end
    assign cacheWord = {22'h000000, cachePhase_ff, hiRatio_ff,
        phaseAlign_ff, tagFall_ff, tagRise_ff, // RQ10 RQ12 RQ17
        cacheRise_ff, cacheFall_ff, wdataDly_ff}; // RQ16 RQ24

    // AHB-Lite: zero wait state, always OKAY; registers are read only
    // a read is decoded in its address phase so that the word already
    // stands on hrdata through the data phase that follows
    logic readReq;
    assign readReq = hready && hsel && htrans[1] && !hwrite;

    // read mux; writes are accepted and ignored since fields are
    // write-once from the rom only
    word_t rdMux;
    always_comb begin
        case (haddr[`REG_ADDR_W-1:0])
            `REG_CTRL: begin
                rdMux = {23'h000000, count_ff};
            end
            `REG_STATUS: begin
                rdMux = {29'h00000000, loadDone,
                         state_ff == LD_SHIFT, romReady};
            end
            `REG_CFG0: begin
                rdMux = {victim_stream_threshold,
                    sys_ratio_onehot, ext_cache_rw_gap, ext_cache_wr_gap,
                    ext_cache_ww_gap, ext_cache_rr_gap,
                    victim_read_ack_inhibit, skew_fill_flag,
                    late_write_upper_flag, write_path_extra_cycle,
                    fill_cmd_delay};
            end
            `REG_CFG1: begin
                rdMux = {sys_shift_load_vector,
                    sys_shift_feedback_points, sys_second_phase_enables,
                    data_valid_delay, ext_cache_clock_cycle_delay};
            end
            `REG_CFG2: begin
                rdMux = {10'h000, frame_ratio_vector,
                    fwdrst_core_delay, fwdrst_proc_delay,
                    fwdrst_frame_delay, sys_fwd_phase_delay,
                    sys_unload_ptr_preset, cache_unload_ptr_preset,
                    sys_fwd_rise_enable, sys_fwd_fall_enable};
            end
            `REG_CFG3: begin
                rdMux = cacheWord;
            end
            `REG_CFG4: begin
                rdMux = {31'h00000000, io32_ff};
            end
            default: begin
                rdMux = 32'h00000000;
            end
        endcase
    end

    // read data launched at the end of the address phase; it holds
    // between reads, which costs nothing and avoids needless toggling
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h00000000;
        end else if (readReq) begin
            hrdata <= rdMux;
        end
    end

    // never stalls and never errors
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

// ==== src/cfg_chain_regs.svh ====
// constants for the write-once configuration chain
`ifndef CFG_CHAIN_REGS_SVH
`define CFG_CHAIN_REGS_SVH
`define CHAIN_ALLOC 367
`define CHAIN_USED 303
`define CHAIN_CNT_W 9
// register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_CFG0 12'h008
`define REG_CFG1 12'h00c
`define REG_CFG2 12'h010
`define REG_CFG3 12'h014
`define REG_CFG4 12'h018
`define REG_ADDR_W 12
// field positions in the used chain, lsb first
`define F_IO32 0
`define F_SKEW 1
`define F_SKEW_DUP 2
`define F_VICTHR 3
`define F_SYSRATIO 15
`define F_RDVIC_INH 26
`define F_WW 34
`define F_RW 35
`define F_RR 41
`define F_WR 43
`define F_TAG_FALL 70
`define F_TAG_RISE 71
`define F_CACHE_PRESET 73
`define F_SYS_PRESET 79
`define F_SYS_DELAY 81
`define F_SYS_RISE 83
`define F_SYS_FALL 84
`define F_FR_CORE 199
`define F_FR_PROC 203
`define F_FR_FRAME 206
`define F_JITTER 213
`define F_FILL_DLY 215
`define F_DV_DLY 219
`define F_CCLK_DLY 223
`define F_SYS_FDBK 255
`define F_SYS_LOAD 263
`define F_SYS_BPH 279
`define F_FRAME 283
`define F_HIRATIO 52
`define F_PHASE_ALIGN 63
`define F_CACHE_PHDLY 64
`define F_LW_UPPER 68
`define F_WDATA_DLY 57
`define F_CACHE_RISE 66
`define F_CACHE_FALL 67
`endif

// ==== src/cfg_chain_pkg.sv ====
// types for the write-once configuration chain
package cfg_chain_pkg;
    typedef enum logic [1:0] {LD_IDLE, LD_SHIFT, LD_DONE} load_e;
    typedef logic [31:0] word_t;
endpackage

// ==== bench/cfg_chain_checker.sv ====
// assertions on the ports of the write-once configuration chain
`timescale 1ns/1ps
`include "cfg_chain_regs.svh"
module cfg_chain_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // rom link
    input wire logic loadStart,
    input wire logic romBitValid,
    input wire logic romReady,
    input wire logic loadDone,
    // a sample of decoded fields
    input wire logic [7:0] victim_stream_threshold,
    input wire logic [3:0] sys_ratio_onehot,
    input wire logic [15:0] sys_shift_load_vector,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp
);
    logic [8:0] bitCnt_ff;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // accepted bits, so the done moment is tied to the very last one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt_ff <= 9'h000;
        end else if (romBitValid && romReady) begin
            bitCnt_ff <= bitCnt_ff + 9'h001;
        end
    end
    a_done_after_all: assert property (
        $rose(loadDone) |-> bitCnt_ff == `CHAIN_ALLOC)
        else $error("load done without the full bit count");
    a_ready_on_start: assert property (
        loadStart && !romReady && !loadDone |=> romReady)
        else $error("start not answered by ready");
    a_no_bits_after: assert property (
        loadDone |-> !romReady)
        else $error("still taking bits after done");
    a_done_sticky: assert property (
        loadDone |=> loadDone)
        else $error("done dropped without reset");
    a_fields_zero: assert property (
        !loadDone |-> victim_stream_threshold == 8'h00
            && sys_ratio_onehot == 4'h0 && sys_shift_load_vector == 16'h0000)
        else $error("fields valid before the final bit");
    a_fields_frozen: assert property (
        loadDone && $past(loadDone) |=> $stable({victim_stream_threshold,
            sys_ratio_onehot, sys_shift_load_vector}))
        else $error("field changed after load");
    a_bus_ready: assert property (hreadyout == 1'b1)
        else $error("bus ready low");
    a_bus_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
endmodule
bind cache_sysport_config_chain cfg_chain_checker i_cfg_chain_checker (
    .clk(clk), .rst_b(rst_b), .loadStart(loadStart),
    .romBitValid(romBitValid), .romReady(romReady), .loadDone(loadDone),
    .victim_stream_threshold(victim_stream_threshold),
    .sys_ratio_onehot(sys_ratio_onehot),
    .sys_shift_load_vector(sys_shift_load_vector),
    .hreadyout(hreadyout), .hresp(hresp)
);

// ==== bench/cfg_rom_model.sv ====
// serial configuration rom model, sends its image msb first
`timescale 1ns/1ps
module cfg_rom_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // image and pacing
    input wire logic go,
    input wire logic [366:0] image,
    input wire logic [3:0] slow,
    // chain link
    input wire logic romReady,
    output logic romBitValid,
    output logic romBit
);
    int left;
    logic [3:0] gap;
    // idle cycles toggle the line so a stale bit never looks valid
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 367;
            gap <= 4'h0;
            romBitValid <= 1'b0;
            romBit <= 1'b0;
        end else if (romBitValid && romReady) begin
            left <= left - 1;
            if (slow == 4'h0 && left > 1) begin
                romBit <= image[left - 2];
            end else begin
                romBitValid <= 1'b0;
                romBit <= ~romBit;
                gap <= slow;
            end
        end else if (!romBitValid) begin
            if (gap != 4'h0) begin
                gap <= gap - 4'h1;
                romBit <= ~romBit;
            end else if (go && romReady && left > 0) begin
                romBitValid <= 1'b1;
                romBit <= image[left - 1];
            end else begin
                romBit <= ~romBit;
            end
        end
    end
endmodule

// ==== bench/testbench.sv ====
// testbench for the write-once configuration chain
`timescale 1ns/1ps
`include "cfg_chain_regs.svh"
module testbench;
    import cfg_chain_pkg::*;
    logic clk, rst_b, loadStart, romBitValid, romBit, romReady, chainOut;
    logic loadDone, skew_fill_flag, victim_read_ack_inhibit, go;
    logic ext_cache_ww_gap, ext_cache_rr_gap, late_write_upper_flag;
    logic sys_fwd_rise_enable, sys_fwd_fall_enable, write_path_extra_cycle;
    logic [7:0] victim_stream_threshold, sys_shift_feedback_points;
    logic [5:0] ext_cache_rw_gap;
    logic [4:0] frame_ratio_vector;
    logic [3:0] sys_ratio_onehot, ext_cache_wr_gap, fwdrst_core_delay, slow;
    logic [3:0] fill_cmd_delay, sys_second_phase_enables;
    logic [2:0] fwdrst_proc_delay, hsize;
    logic [1:0] sys_fwd_phase_delay, sys_unload_ptr_preset, htrans;
    logic [1:0] cache_unload_ptr_preset, fwdrst_frame_delay;
    logic [1:0] data_valid_delay, ext_cache_clock_cycle_delay;
    logic [15:0] sys_shift_load_vector;
    logic hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr;
    logic [366:0] img;
    word_t hwdata, hrdata, rd;
    int miscompares, samplesChecked;
    // the slave's own ready closes the bus loop
    cache_sysport_config_chain i_cache_sysport_config_chain (
        .clk, .rst_b, .loadStart, .romBitValid, .romBit, .romReady,
        .chainOut, .loadDone, .skew_fill_flag, .victim_stream_threshold,
        .sys_ratio_onehot, .victim_read_ack_inhibit, .ext_cache_ww_gap,
        .ext_cache_rw_gap, .ext_cache_rr_gap, .ext_cache_wr_gap,
        .late_write_upper_flag, .sys_fwd_phase_delay, .sys_unload_ptr_preset,
        .cache_unload_ptr_preset, .sys_fwd_rise_enable, .sys_fwd_fall_enable,
        .fwdrst_core_delay, .fwdrst_proc_delay, .fwdrst_frame_delay,
        .write_path_extra_cycle, .fill_cmd_delay, .data_valid_delay,
        .ext_cache_clock_cycle_delay, .sys_shift_feedback_points,
        .sys_shift_load_vector, .sys_second_phase_enables,
        .frame_ratio_vector, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp
    );
    cfg_rom_model i_cfg_rom_model (
        .clk, .rst_b, .go, .image(img), .slow, .romReady, .romBitValid,
        .romBit
    );
    // free running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic finalReport();
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer; hready and hrdata taken at rising edges
    task automatic bus(input logic wr, input logic [11:0] a, input word_t wd,
                       output word_t r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    function automatic logic [31:0] f(input int p, input int w);
        f = 32'(img >> p) & ((32'h1 << w) - 32'h1);
    endfunction
    task automatic checkFields();
        chk(skew_fill_flag, f(`F_SKEW, 1));
        chk(victim_stream_threshold, f(`F_VICTHR, 8));
        chk(sys_ratio_onehot, f(`F_SYSRATIO, 4));
        chk(victim_read_ack_inhibit, f(`F_RDVIC_INH, 1));
        chk(ext_cache_ww_gap, f(`F_WW, 1));
        chk(ext_cache_rw_gap, f(`F_RW, 6));
        chk(ext_cache_rr_gap, f(`F_RR, 1));
        chk(ext_cache_wr_gap, f(`F_WR, 4));
        chk(late_write_upper_flag, f(`F_LW_UPPER, 1));
        chk(sys_fwd_phase_delay, f(`F_SYS_DELAY, 2));
        chk(sys_unload_ptr_preset, f(`F_SYS_PRESET, 2));
        chk(cache_unload_ptr_preset, f(`F_CACHE_PRESET, 2));
        chk({sys_fwd_rise_enable, sys_fwd_fall_enable}, 32'h3);
        chk(fwdrst_core_delay, f(`F_FR_CORE, 4));
        chk(fwdrst_proc_delay, f(`F_FR_PROC, 3));
        chk(fwdrst_frame_delay, f(`F_FR_FRAME, 2));
        chk(write_path_extra_cycle, f(`F_JITTER, 1));
        chk(fill_cmd_delay, f(`F_FILL_DLY, 4));
        chk(data_valid_delay, f(`F_DV_DLY, 2));
        chk(ext_cache_clock_cycle_delay, f(`F_CCLK_DLY, 2));
        chk(sys_shift_feedback_points, f(`F_SYS_FDBK, 8));
        chk(sys_shift_load_vector, f(`F_SYS_LOAD, 16));
        chk(sys_second_phase_enables, f(`F_SYS_BPH, 4));
        chk(frame_ratio_vector, f(`F_FRAME, 5));
    endtask
    // hang guard, far beyond four loads at the slowest pacing
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finalReport();
    end
    // one reset and load per ratio code, paced with slow 0, 1, 2 and then 0 again
    initial begin
        {rst_b, loadStart, go, hsel, hwrite} = 5'h00;
        {haddr, htrans, hwdata, slow} = '0;
        hsize = 3'b010;
        img = '0;
        for (int pass = 0; pass < 4; pass++) begin
            rst_b <= 1'b0;
            go <= 1'b0;
            slow <= (pass == 3) ? 4'h0 : 4'(pass);
            img = 367'({12{32'h9e3779b9 + 32'(pass) * 32'h01234567}});
            img[`F_SKEW] = (pass == 0);
            img[`F_SKEW_DUP] = (pass == 0);
            img[`F_SYSRATIO +: 4] = 4'h1 << pass;
            img[`F_SYS_RISE] = 1'b1;
            img[`F_SYS_FALL] = 1'b1;
            img[`F_CACHE_RISE] = 1'b1;
            img[`F_CACHE_FALL] = 1'b1;
            repeat (16) @(posedge clk);
            rst_b <= 1'b1;
            bus(1'b0, `REG_STATUS, 32'h0, rd);
            chk(rd, 32'h0);
            loadStart <= 1'b1;
            @(posedge clk);
            loadStart <= 1'b0;
            go <= 1'b1;
            do @(negedge clk); while (loadDone !== 1'b1);
            repeat (2) @(negedge clk);
            checkFields();
            chk(chainOut, img[303]);
            bus(1'b0, `REG_CTRL, 32'h0, rd);
            chk(rd, 32'd367);
            bus(1'b0, `REG_STATUS, 32'h0, rd);
            chk(rd, 32'h4);
            bus(1'b0, 12'h040, 32'h0, rd);
            chk(rd, 32'h0);
            bus(1'b0, `REG_CFG3, 32'h0, rd);
            chk(rd[6:3], {img[`F_HIRATIO], img[`F_PHASE_ALIGN],
                img[`F_TAG_FALL], img[`F_TAG_RISE]});
            chk(rd[2:0], {2'b11, img[`F_WDATA_DLY]});
            chk(rd[9:7], (img[`F_CACHE_PHDLY +: 2] == 2'h3) ? 32'h2 :
                32'(img[`F_CACHE_PHDLY +: 2] == 2'h2));
            bus(1'b0, `REG_CFG4, 32'h0, rd);
            chk(rd, {31'h0, img[`F_IO32]});
            // a second start and bus writes must leave every decoded output field alone
            loadStart <= 1'b1;
            @(posedge clk);
            loadStart <= 1'b0;
            bus(1'b1, `REG_CFG0, 32'hffffffff, rd);
            bus(1'b1, `REG_CTRL, 32'h0, rd);
            repeat (8) @(negedge clk);
            checkFields();
            bus(1'b0, `REG_CTRL, 32'h0, rd);
            chk(rd, 32'd367);
        end
        finalReport();
    end
endmodule
